// >>> design/msi_gen_map.svh
// Purpose: Register map, field positions and reset values of the message generator
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes:   Definitions only
`ifndef MSI_GEN_MAP_SVH
`define MSI_GEN_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_STATUS       8'hB8
`define OFS_CONTROL      8'hC0
`define OFS_ADDR_LO      8'hC4
`define OFS_ADDR_HI      8'hC8
`define OFS_PAYLOAD      8'hCC

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTL_ENABLE_BIT   0
`define CTL_CAPABLE_LSB  1
`define CTL_ALLOC_LSB    4
`define CTL_WIDE_BIT     7
`define CTL_WIDE_CAP     1'b1
`define CTL_CAPABLE_VAL  3'h5

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define STS_BUSY_BIT     0
`define STS_LEGACY_BIT   1
`define STS_OVERRUN_BIT  2
`define STS_COUNT_LSB    16

// ----------------------------------------------------------------
// Reset values and bus constants
// ----------------------------------------------------------------
`define RST_ADDR_LO      30'h0000_0000
`define RST_ADDR_HI      32'h0000_0000
`define RST_PAYLOAD      16'h0000
`define RST_ALLOC        3'h0
`define HTRANS_NONSEQ_B1 1'b1
`define HSIZE_WORD       3'h2
`define ALL_LANES_N      4'h0

`endif

// >>> design/msi_gen_pkg.sv
// Purpose: Types shared by the message generator
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in msi_gen_map.svh
package msi_gen_pkg;

    // ----------------------------------------------------------------
    // Transaction sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } msg_state_e;

    typedef logic [4:0] vector_t;

endpackage

// >>> design/msi_message_generator.sv
// Purpose: Message-signalled interrupt generator with AHB-Lite registers
// Assumes: One clock; event source and write receiver on sys_clk
// Notes:   One message in flight plus one waiting event
`timescale 1ns/10ps
`include "msi_gen_map.svh"

module msi_message_generator
    import msi_gen_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        irqReq,
    input  wire vector_t     irqVector,
    output logic             irqReady,
    output logic             msgAddrPhase,
    output logic             msgDataPhase,
    output logic [63:0]      msgAddr,
    output logic             msgDual,
    output logic [31:0]      msgData,
    output logic [3:0]       msgByteEn_n,
    input  wire logic        msgAck,
    output logic             legacyInt_n
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic vector_t allocMask(input logic [2:0] alloc);
        unique case (alloc)
            3'h0:    allocMask = 5'h00;
            3'h1:    allocMask = 5'h01;
            3'h2:    allocMask = 5'h03;
            3'h3:    allocMask = 5'h07;
            3'h4:    allocMask = 5'h0F;
            3'h5:    allocMask = 5'h1F;
            default: allocMask = 5'h00;  // Reserved codes grant a single vector
        endcase
    endfunction

    function automatic logic [15:0] mergeVector(input logic [15:0] base,
                                                input vector_t     vec,
                                                input vector_t     mask);
        mergeVector = {base[15:5], (base[4:0] & ~mask) | (vec & mask)};
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:2] addrLo;
    logic [31:0] addrHi;
    logic [15:0] payload;
    logic        msgEnable;
    logic [2:0]  alloc;
    logic        legacyPend;
    logic        overrun;
    logic [15:0] sentCount;

    // Event holding slot and sequencer
    logic        pendValid;
    vector_t     pendVector;
    msg_state_e  state;
    logic [15:0] dataShadow;

    // Bus data-phase capture
    logic        wrPending;
    logic [7:0]  wrOffset;

    logic        busSel;
    logic        busWrite;
    logic        startMsg;
    logic        takeEvent;
    logic        divertEvent;
    logic        wideUsed;
    logic [31:0] readMux;
    logic [31:0] statusWord;
    logic [31:0] controlWord;

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    assign busSel   = hsel & hready & (htrans[1] == `HTRANS_NONSEQ_B1);
    assign busWrite = wrPending;

    assign statusWord  = {sentCount, 13'h0000, overrun, legacyPend,
                          (state != ST_IDLE) | pendValid};
    assign controlWord = {24'h000000, `CTL_WIDE_CAP, alloc,
                          `CTL_CAPABLE_VAL, msgEnable};

    always_comb begin
        unique case (haddr[7:0])
            `OFS_STATUS:  readMux = statusWord;
            `OFS_CONTROL: readMux = controlWord;
            `OFS_ADDR_LO: readMux = {addrLo, 2'b00};
            `OFS_ADDR_HI: readMux = `CTL_WIDE_CAP ? addrHi : 32'h0000_0000;
            `OFS_PAYLOAD: readMux = {16'h0000, payload};
            default:      readMux = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h000000) begin
            readMux = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wrPending <= 1'b0;
            wrOffset  <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            // Sub-word or out-of-page writes are dropped rather than half applied
            wrPending <= busSel & hwrite & (hsize == `HSIZE_WORD)
                         & (haddr[31:8] == 24'h000000);
            wrOffset  <= haddr[7:0];
            if (busSel & ~hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addrLo    <= `RST_ADDR_LO;
            addrHi    <= `RST_ADDR_HI;
            payload   <= `RST_PAYLOAD;
            msgEnable <= 1'b0;
            alloc     <= `RST_ALLOC;
        end else if (busWrite) begin
            unique case (wrOffset)
                `OFS_CONTROL: begin
                    msgEnable <= hwdata[`CTL_ENABLE_BIT];
                    alloc     <= hwdata[`CTL_ALLOC_LSB +: 3];
                end
                `OFS_ADDR_LO: addrLo  <= hwdata[31:2];
                `OFS_ADDR_HI: addrHi  <= `CTL_WIDE_CAP ? hwdata : 32'h0000_0000;
                `OFS_PAYLOAD: payload <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event intake
    // ----------------------------------------------------------------
    // One waiting slot keeps the source decoupled from a slow receiver
    assign takeEvent   = irqReq & ~pendValid;
    assign startMsg    = (state == ST_IDLE) & pendValid & msgEnable;
    assign divertEvent = pendValid & ~msgEnable;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendValid  <= 1'b0;
            pendVector <= 5'h00;
        end else begin
            if (takeEvent) begin
                pendValid  <= 1'b1;
                pendVector <= irqVector;
            end else if (startMsg | divertEvent) begin
                pendValid  <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqReady <= 1'b0;
        end else begin
            irqReady <= ~(pendValid | takeEvent) | startMsg | divertEvent;
        end
    end

    // ----------------------------------------------------------------
    // Status flags; hardware set wins over a software clear
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            legacyPend <= 1'b0;
            overrun    <= 1'b0;
        end else begin
            if (divertEvent) begin
                legacyPend <= 1'b1;
            end else if (busWrite && wrOffset == `OFS_STATUS
                         && hwdata[`STS_LEGACY_BIT]) begin
                legacyPend <= 1'b0;
            end
            if (irqReq & pendValid) begin
                overrun <= 1'b1;
            end else if (busWrite && wrOffset == `OFS_STATUS
                         && hwdata[`STS_OVERRUN_BIT]) begin
                overrun <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            legacyInt_n <= 1'b1;
        end else begin
            // The legacy pin stays quiet whenever message signalling is on
            legacyInt_n <= ~(legacyPend & ~msgEnable);
        end
    end

    // ----------------------------------------------------------------
    // Memory write sequencer
    // ----------------------------------------------------------------
    assign wideUsed = `CTL_WIDE_CAP & (addrHi != 32'h0000_0000);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (startMsg) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (msgAck) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // A started write always completes; cutting it would hang the receiver
                    if (msgAck) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Address and payload are sampled at start so later writes cannot tear a message
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msgAddr    <= 64'h0000_0000_0000_0000;
            msgDual    <= 1'b0;
            dataShadow <= 16'h0000;
        end else if (startMsg) begin
            msgAddr    <= {wideUsed ? addrHi : 32'h0000_0000,
                           addrLo, 2'b00};
            msgDual    <= wideUsed;
            dataShadow <= mergeVector(payload, pendVector,
                                      allocMask(alloc));
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msgAddrPhase <= 1'b0;
            msgDataPhase <= 1'b0;
            msgData      <= 32'h0000_0000;
            msgByteEn_n  <= 4'hF;
        end else begin
            msgAddrPhase <= startMsg | ((state == ST_ADDR) & ~msgAck);
            msgDataPhase <= ((state == ST_ADDR) & msgAck)
                            | ((state == ST_DATA) & ~msgAck);
            if ((state == ST_ADDR) & msgAck) begin
                msgData     <= {16'h0000, dataShadow};
                msgByteEn_n <= `ALL_LANES_N;
            end else if ((state == ST_DATA) & msgAck) begin
                msgData     <= 32'h0000_0000;
                msgByteEn_n <= 4'hF;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sentCount <= 16'h0000;
        end else if ((state == ST_DATA) & msgAck) begin
            sentCount <= sentCount + 16'h0001;
        end
    end

endmodule // msi_message_generator

// >>> tb/msi_gen_checker_asserts.sv
// Purpose: Port checks on the message generator
// Assumes: One clock, async active-high reset
// Notes:   Bound to every generator instance
`timescale 1ns/10ps
module msi_gen_checker (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        msgAddrPhase,
    input wire logic        msgDataPhase,
    input wire logic [63:0] msgAddr,
    input wire logic        msgDual,
    input wire logic [31:0] msgData,
    input wire logic [3:0]  msgByteEn_n,
    input wire logic        msgAck,
    input wire logic        legacyInt_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Steps of one message, and a read of the low address register
    // ----------------------------------------------------------------
    sequence addrTaken;
        msgAddrPhase && msgAck;
    endsequence
    sequence dataTaken;
        msgDataPhase && msgAck;
    endsequence
    sequence lowRead;
        hsel && hready && htrans[1] && !hwrite && haddr == 32'h000000C4;
    endsequence
    addr_low_a: assert property (msgAddrPhase |-> msgAddr[1:0] == 2'b00)
        else $error("message address low bits not zero");
    addr_hold_a: assert property (
        msgAddrPhase && !msgAck |=> msgAddrPhase && $stable(msgAddr))
        else $error("address phase changed before acceptance");
    read_low_a: assert property (lowRead |=> hrdata[1:0] == 2'b00)
        else $error("address register low bits read non-zero");
    wide_addr_a: assert property (
        msgAddrPhase && msgDual |-> msgAddr[63:32] != 32'h0)
        else $error("wide write with zero upper address");
    narrow_addr_a: assert property (
        msgAddrPhase && !msgDual |-> msgAddr[63:32] == 32'h0)
        else $error("narrow write with upper address bits");
    high_half_a: assert property (msgDataPhase |-> msgData[31:16] == 16'h0)
        else $error("data high half not zero");
    phase_step_a: assert property (
        addrTaken |=> msgDataPhase && !msgAddrPhase && msgByteEn_n == 4'h0)
        else $error("data phase did not follow accepted address");
    data_end_a: assert property (
        dataTaken |=> !msgDataPhase && msgByteEn_n == 4'hF)
        else $error("data phase did not end after acceptance");
    legacy_quiet_a: assert property ($rose(msgAddrPhase) |-> legacyInt_n)
        else $error("message started while legacy line asserted");
endmodule // msi_gen_checker

bind msi_message_generator msi_gen_checker i_msi_gen_checker (.sys_clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .msgAddrPhase, .msgDataPhase, .msgAddr,
    .msgDual, .msgData, .msgByteEn_n, .msgAck, .legacyInt_n);

// >>> tb/msi_receiver_model.sv
// Purpose: Interrupt receiver taking message writes
// Assumes: Same clock as the generator
// Notes:   Accepts each phase after ackDelay waiting cycles
`timescale 1ns/10ps
module msi_receiver_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        msgAddrPhase,
    input  wire logic        msgDataPhase,
    input  wire logic [63:0] msgAddr,
    input  wire logic        msgDual,
    input  wire logic [31:0] msgData,
    input  wire logic [1:0]  ackDelay,
    output logic             msgAck,
    output logic             gotMsg,
    output logic [63:0]      gotAddr,
    output logic             gotDual,
    output logic [31:0]      gotData
);
    logic [1:0] waitCnt;
    // Ack drops right after each acceptance so one ack never covers two phases
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msgAck <= 1'b0;
            waitCnt <= 2'h0;
            gotMsg <= 1'b0;
        end else begin
            gotMsg <= 1'b0;
            if (msgAck) begin
                msgAck <= 1'b0;
                waitCnt <= 2'h0;
                gotAddr <= msgAddrPhase ? msgAddr : gotAddr;
                gotDual <= msgAddrPhase ? msgDual : gotDual;
                gotData <= msgData;
                gotMsg <= msgDataPhase;
            end else if ((msgAddrPhase || msgDataPhase) && waitCnt == ackDelay) begin
                msgAck <= 1'b1;
            end else if (msgAddrPhase || msgDataPhase) begin
                waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule // msi_receiver_model

// >>> tb/test_msi_message_generator.sv
// Purpose: Self-checking bench of the message generator
// Assumes: Receiver model answers each phase
// Notes:   Messages are checked in order of the events
`timescale 1ns/10ps
module test_msi_message_generator
    import msi_gen_pkg::*;
;
    logic sys_clk, sys_rst, hsel, hwrite, irqReq, gotMsg, gotDual, msgAck, legacyInt_n;
    logic [31:0] haddr, hwdata, hrdata, gotData, msgData, lo, hi, pl, rd;
    logic [1:0] htrans, ackDelay;
    logic [63:0] gotAddr, msgAddr;
    logic [96:0] expQ[$];
    logic hready, hresp, irqReady, msgAddrPhase, msgDataPhase, msgDual;
    logic [3:0] msgByteEn_n;
    vector_t irqVector;
    int nMismatch = 0;
    int checkCount = 0;
    int seed;

    msi_message_generator i_msi_message_generator (.sys_clk, .sys_rst, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hrdata,
        .hresp, .irqReq, .irqVector, .irqReady, .msgAddrPhase, .msgDataPhase, .msgAddr,
        .msgDual, .msgData, .msgByteEn_n, .msgAck, .legacyInt_n);
    msi_receiver_model i_msi_receiver_model (.sys_clk, .sys_rst, .msgAddrPhase,
        .msgDataPhase, .msgAddr, .msgDual, .msgData, .ackDelay, .msgAck, .gotMsg,
        .gotAddr, .gotDual, .gotData);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [96:0] seen, input logic [96:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic limit(input int n);
        if (n >= 200) begin
            nMismatch++;
            finishTest();
        end
    endtask
    // ----------------------------------------------------------------
    // Bus and event drivers
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        n = 0;
        do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 200);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 200);
        rd = hrdata;
        limit(n);
    endtask
    task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check("register", rd, exp);
        check("response", hresp, 1'b0);
    endtask
    task automatic fire(input vector_t v, input int len);
        int n;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (irqReady !== 1'b1 && n < 200);
        limit(n);
        irqReq <= 1'b1;
        irqVector <= v;
        repeat (len) @(posedge sys_clk);
        irqReq <= 1'b0;
    endtask
    task automatic expectMsg(input logic [2:0] al, input vector_t v);
        vector_t m;
        m = (al > 3'h5) ? 5'h0 : 5'((6'h1 << al) - 6'h1);
        expQ.push_back({hi != 32'h0, hi, lo & 32'hFFFFFFFC, 16'h0,
            pl[15:0] & ~{11'h0, m} | {11'h0, v & m}});
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 200) begin @(posedge sys_clk); n++; end
        limit(n);
        repeat (2) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (gotMsg === 1'b1) begin
            if (expQ.size() == 0)
                check("spare message", {gotDual, gotAddr, gotData}, 97'h0);
            else
                check("message", {gotDual, gotAddr, gotData}, expQ.pop_front());
        end
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        irqReq = 1'b0;
        irqVector = 5'h00;
        ackDelay = 2'h0;
        seed = $urandom(67060);
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        // ----------------------------------------------------------------
        // Reset values, read-only bits, unmapped place
        // ----------------------------------------------------------------
        regRd(8'hC4, 32'h0);
        regRd(8'hC8, 32'h0);
        regRd(8'hCC, 32'h0);
        regRd(8'hC0, 32'h0000008A);
        regRd(8'h10, 32'h0);
        xfer(1'b1, 8'hC4, 32'hFFFFFFFF);
        regRd(8'hC4, 32'hFFFFFFFC);
        xfer(1'b1, 8'hCC, 32'hFFFFFFFF);
        regRd(8'hCC, 32'h0000FFFF);
        // Disabled: legacy line instead of a message
        fire(5'h3, 1);
        repeat (4) @(posedge sys_clk);
        check("legacy line", legacyInt_n, 1'b0);
        regRd(8'hB8, 32'h2);
        xfer(1'b1, 8'hB8, 32'h2);
        // Every allocation code, two events back to back
        for (int al = 0; al < 8; al++) begin
            lo = $urandom;
            hi = al[0] ? $urandom : 32'h0;
            pl = $urandom & 32'hFFFF;
            xfer(1'b1, 8'hC4, lo);
            xfer(1'b1, 8'hC8, hi);
            xfer(1'b1, 8'hCC, pl);
            xfer(1'b1, 8'hC0, {25'h0, al[2:0], 4'h1});
            ackDelay <= 2'($urandom);
            for (int k = 0; k < 2; k++) begin
                irqVector <= 5'($urandom);
                @(posedge sys_clk);
                expectMsg(al[2:0], irqVector);
                fire(irqVector, 1);
            end
            drain();
        end
        regRd(8'hB8, 32'h00100000);
        // Two-cycle pulse: second event refused, one message only
        expectMsg(3'h7, 5'h1F);
        fire(5'h1F, 2);
        // Slot was full when the second edge sampled the pulse
        check("slot ready", irqReady, 1'b0);
        drain();
        regRd(8'hB8, 32'h00110004);
        finishTest();
    end
endmodule // test_msi_message_generator
